/* rtl/idf_dio_top.sv */
// Isolated digital I/O core: output latch, debounced inputs, edge interrupts.
// Assumes a classic Wishbone master, pins asynchronous to clk_i.
//
// Notes on behaviour
// [RULE1] An ON input reads as 1, an OFF input as 0.
// [RULE2] Output bit 1 turns its transistor on, 0 turns it off.
// [RULE3] All output bits are 0 after reset.
// [RULE4] Reading the output register returns the driven value and leaves it alone.
// [RULE5] Filtered level follows raw only after it held for the filter time.
// [RULE6] Codes 0 to 20 accepted; code 0 passes inputs unfiltered.
// [RULE7] Code n needs 2**n periods of the 8 MHz reference.
// [RULE8] Filter code is 0 after reset.
// [RULE9] One filter code serves every channel.
// [RULE10] Software keeps the filter code at 20 or below.
// [RULE11] Every input can request an interrupt on a level change.
// [RULE12] With filtering active, edges are taken from filtered levels.
// [RULE13] A masked channel raises no interrupt request.
// [RULE14] A masked channel never sets its status bit.
// [RULE15] Edge select 0 fires on 0 to 1, 1 fires on 1 to 0.
// [RULE16] Edge select bits are 0 after reset.
// [RULE17] Status bits name the sources; reading them clears status and request.
// [RULE18] Status bits are 0 after reset.
// [RULE19] Interrupt request is a level held while any status bit is set.
// [RULE20] Mask bit 1 disables, 0 enables; all masks are 1 after reset.
// [RULE21] Per-channel counter at 8 MHz restarts on raw change, commits at count.
`timescale 1ns/1ps
module idf_dio_top
    import idf_pkg::*;
#(
    parameter int unsigned N_CH = 32,
    parameter int unsigned TICK_DIV = REF_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [N_CH-1:0] din_i,
    output logic [N_CH-1:0] dout_o,
    output logic irq_o
);

    if (N_CH < 1 || N_CH > MAX_CH)
    begin : g_chk
        $error("idf_dio_top: N_CH must be 1 to 32");
    end

    localparam logic [31:0] CH_MASK = 32'((64'h1 << N_CH) - 64'h1);

    // Byte-lane merge for register writes
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_sel

    // Address match; unaligned addresses never match
    function automatic logic is_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction : is_hit

    // Stable-time limit for a code; larger codes are held at the top value
    function automatic logic [FIL_CNT_W-1:0] code_limit(input logic [4:0] c);
        logic [4:0] n;
        n = (c > 5'(FIL_CODE_MAX)) ? 5'(FIL_CODE_MAX) : c; // [RULE10]
        return FIL_CNT_W'((64'h1 << n) - 64'h1); // [RULE7]
    endfunction : code_limit

    idf_cfg_t cfg;
    idf_wb_req_t req;
    logic bus_go;
    logic stat_clr;
    logic tick;
    logic bypass;
    logic [FIL_CNT_W-1:0] limit;
    logic [N_CH-1:0] din_meta;
    logic [N_CH-1:0] din_sync;
    logic [N_CH-1:0] filt;
    logic [N_CH-1:0] filt_q;
    logic [N_CH-1:0] wdat_lo;
    logic [31:0] filt32;
    logic [31:0] evt;
    logic [31:0] status;
    logic [31:0] next_status;
    logic [31:0] rd_data;
    logic [31:0] mask_q;

    // Request bundle and the single cycle on which it is served
    assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
    assign bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign stat_clr = bus_go & ~req.we & is_hit(req.adr, OFF_STAT);
    assign wdat_lo = wb_dat_i[N_CH-1:0];
    assign mask_q = cfg.mask;

    // Pins are asynchronous; the first stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            din_meta <= '0;
            din_sync <= '0;
        end
        else if (ce_i)
        begin
            din_meta <= din_i;
            din_sync <= din_meta;
        end
    end

    // Reference tick shared by all channels
    idf_ref_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_o(tick)
    );

    // One code for all channels, no per-channel setting exists
    assign bypass = (cfg.code == 5'h00); // [RULE6] [RULE9]
    assign limit = code_limit(cfg.code); // [RULE9]

    for (genvar i = 0; i < N_CH; i++)
    begin : g_chan
        idf_filter_chan #(
            .CW(FIL_CNT_W)
        ) u_filt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .tick_i(tick),
            .bypass_i(bypass),
            .limit_i(limit),
            .raw_i(din_sync[i]),
            .filt_o(filt[i])
        );
    end

    assign filt32 = 32'(filt);

    // Configuration registers; writes land on the edge that raises ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg <= '{dout: RST_DOUT, mask: RST_MASK & CH_MASK, // [RULE3] [RULE20]
                     edge_sel: RST_EDGE, code: RST_FCODE}; // [RULE16] [RULE8]
        end
        else if (ce_i && bus_go && req.we)
        begin
            if (is_hit(req.adr, OFF_DOUT))
            begin
                cfg.dout <= apply_sel(cfg.dout, req.dat, req.sel) & CH_MASK; // [RULE2]
            end
            if (is_hit(req.adr, OFF_MASK))
            begin
                cfg.mask <= apply_sel(cfg.mask, req.dat, req.sel) & CH_MASK;
            end
            if (is_hit(req.adr, OFF_EDGE))
            begin
                cfg.edge_sel <= apply_sel(cfg.edge_sel, req.dat, req.sel) & CH_MASK;
            end
            if (is_hit(req.adr, OFF_FCODE) && req.sel[0])
            begin
                cfg.code <= req.dat[CODE_W-1:0];
            end
        end
    end

    // Output latch drives the transistors directly
    assign dout_o = cfg.dout[N_CH-1:0]; // [RULE2] [RULE4]

    // Previous filtered level for edge detection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            filt_q <= '0;
        end
        else if (ce_i)
        begin
            filt_q <= filt; // [RULE12]
        end
    end

    // Edge events on filtered levels, gated by mask before they reach status
    always_comb
    begin
        evt = 32'((filt & ~filt_q & ~cfg.edge_sel[N_CH-1:0]) | // [RULE15] [RULE11]
                  (~filt & filt_q & cfg.edge_sel[N_CH-1:0])); // [RULE15]
        evt = evt & ~cfg.mask; // [RULE13] [RULE14]
    end

    // A new event in the read cycle survives the clear
    assign next_status = (status & ~{32{stat_clr}}) | evt; // [RULE17]

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            status <= RST_STAT; // [RULE18]
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            status <= next_status;
            irq_o <= |next_status; // [RULE19]
        end
    end

    // Read data selection; unmapped addresses read zero
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (is_hit(req.adr, OFF_DIN))
        begin
            rd_data = filt32; // [RULE1]
        end
        else if (is_hit(req.adr, OFF_DOUT))
        begin
            rd_data = cfg.dout; // [RULE4]
        end
        else if (is_hit(req.adr, OFF_FCODE))
        begin
            rd_data = 32'(cfg.code);
        end
        else if (is_hit(req.adr, OFF_MASK))
        begin
            rd_data = cfg.mask;
        end
        else if (is_hit(req.adr, OFF_EDGE))
        begin
            rd_data = cfg.edge_sel;
        end
        else if (is_hit(req.adr, OFF_STAT))
        begin
            rd_data = status; // [RULE17]
        end
    end

    // One wait state; every access, mapped or not, is acknowledged
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= bus_go;
            if (bus_go && !req.we)
            begin
                wb_dat_o <= rd_data;
            end
        end
    end

    a_out_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (dout_o == '0)) // [RULE3]
        else $error("outputs not off after reset");

    a_code_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (cfg.code == 5'h00 && bypass)) // [RULE8]
        else $error("filter code not cleared by reset");

    a_edge_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (cfg.edge_sel == 32'h0000_0000)) // [RULE16]
        else $error("edge selects not cleared by reset");

    a_stat_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (status == 32'h0000_0000 && !irq_o)) // [RULE18]
        else $error("status or request pending after reset");

    a_mask_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_i) |-> (cfg.mask == CH_MASK)) // [RULE20]
        else $error("masks not set by reset");

    a_out_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && bus_go && req.we && is_hit(req.adr, OFF_DOUT) && req.sel == 4'hf)
        |=> (dout_o == $past(wdat_lo))) // [RULE2]
        else $error("output write not driven");

    a_out_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && bus_go && !req.we && is_hit(req.adr, OFF_DOUT))
        |=> (wb_ack_o && wb_dat_o == 32'(dout_o) && $stable(dout_o))) // [RULE4]
        else $error("output read-back wrong or disturbed");

    a_in_report: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && bus_go && !req.we && is_hit(req.adr, OFF_DIN))
        |=> (wb_dat_o == $past(filt32))) // [RULE1]
        else $error("input read does not show input level");

    a_in_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && cfg.code == 5'h00) |=> (filt == $past(din_sync))) // [RULE6]
        else $error("code zero does not pass inputs through");

    a_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> ((status & ~$past(status) & $past(mask_q)) == 32'h0000_0000)) // [RULE14]
        else $error("masked channel set its status");

    a_edge_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !cfg.mask[0] && !cfg.edge_sel[0] && filt[0] && !filt_q[0])
        |=> (status[0] && irq_o)) // [RULE15]
        else $error("rising edge did not raise status and request");

    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (|status)) // [RULE19]
        else $error("request does not follow status");

    a_stat_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && stat_clr && evt == 32'h0000_0000)
        |=> (status == 32'h0000_0000 && !irq_o && wb_ack_o)) // [RULE17]
        else $error("status read did not clear");

endmodule : idf_dio_top

/* rtl/idf_pkg.sv */
// Shared constants, register map and carrier types of the isolated DIO block.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone register bus.
package idf_pkg;

    // Clock and filter reference timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned REF_PERIOD_NS = 125;
    localparam int unsigned REF_DIV = (REF_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;

    // Filter code range and stability counter width
    localparam int unsigned FIL_CODE_MAX = 20;
    localparam int unsigned FIL_CNT_W = 21;
    localparam int unsigned CODE_W = 5;
    localparam int unsigned MAX_CH = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_DIN = 8'h00;
    localparam logic [7:0] OFF_DOUT = 8'h04;
    localparam logic [7:0] OFF_FCODE = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0c;
    localparam logic [7:0] OFF_EDGE = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;

    // Reset values
    localparam logic [31:0] RST_DOUT = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'hffff_ffff;
    localparam logic [31:0] RST_EDGE = 32'h0000_0000;
    localparam logic [31:0] RST_STAT = 32'h0000_0000;
    localparam logic [4:0] RST_FCODE = 5'h00;

    // Software-written configuration
    typedef struct packed {
        logic [31:0] dout;
        logic [31:0] mask;
        logic [31:0] edge_sel;
        logic [4:0] code;
    } idf_cfg_t;

    // One Wishbone request as seen by the slave
    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } idf_wb_req_t;

endpackage : idf_pkg

/* rtl/idf_ref_tick.sv */
// Divider that makes a one-cycle tick at the filter reference rate.
// Assumes a free-running system clock; ce_i low freezes the count.
`timescale 1ns/1ps
module idf_ref_tick #(
    parameter int unsigned DIV = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    output logic tick_o
);

    if (DIV < 1 || DIV > 65535)
    begin : g_chk
        $error("idf_ref_tick: DIV out of range");
    end

    logic [15:0] cnt;

    // Count system clocks; the tick marks the last one of each period
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 16'h0000;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cnt == 16'(DIV - 1))
            begin
                cnt <= 16'h0000;
                tick_o <= 1'b1;
            end
            else
            begin
                cnt <= cnt + 16'h0001;
                tick_o <= 1'b0;
            end
        end
    end

endmodule : idf_ref_tick

/* rtl/idf_filter_chan.sv */
// One channel of the input debounce filter with its stability counter.
// Assumes raw_i is already synchronised and tick_i is a one-cycle pulse.
`timescale 1ns/1ps
module idf_filter_chan
    import idf_pkg::*;
#(
    parameter int unsigned CW = FIL_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic bypass_i,
    input wire logic [CW-1:0] limit_i,
    input wire logic raw_i,
    output logic filt_o
);

    // The limit port and the counter share this width
    if (CW < 1 || CW > 32)
    begin : g_chk
        $error("idf_filter_chan: CW out of range");
    end

    logic [CW-1:0] cnt;

    // Any return of the raw level to the held level restarts the count
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= '0;
            filt_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (bypass_i)
            begin
                filt_o <= raw_i; // [RULE6]
                cnt <= '0;
            end
            else if (raw_i == filt_o)
            begin
                cnt <= '0; // [RULE21]
            end
            else if (tick_i)
            begin
                if (cnt == limit_i)
                begin
                    filt_o <= raw_i; // [RULE5] [RULE7]
                    cnt <= '0;
                end
                else
                begin
                    cnt <= cnt + 1'b1; // [RULE21]
                end
            end
        end
    end

    a_filt_commit: assert property (@(posedge clk_i) disable iff (rst_i)
        (!(ce_i && (bypass_i || (tick_i && cnt == limit_i)))) |=> $stable(filt_o)) // [RULE5]
        else $error("filtered level changed before the stable time");

    a_filt_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && raw_i == filt_o) |=> (cnt == '0)) // [RULE21]
        else $error("stability counter did not restart");

endmodule : idf_filter_chan

/* tb/idf_host_model.sv */
// Host-side model: issues classic Wishbone single cycles to the DIO block.
// Assumes one ack per request; the bench watchdog ends a hung wait.
`timescale 1ns/1ps
module idf_host_model
    import idf_pkg::*;
(
    input wire logic clk_i,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    // Bus idle from time zero
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // One access; request held until the edge that samples ack high
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                        input logic [3:0] sel, output logic [31:0] rdat);
        if (we && adr == OFF_FCODE && wdat > FIL_CODE_MAX)
            wdat = FIL_CODE_MAX; // Out-of-range codes never sent
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= wdat;
        do
        begin
            @(posedge clk_i);
        end while (wb_ack_i !== 1'b1);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
    endtask : xfer
endmodule : idf_host_model

/* tb/tb.sv */
// Self-checking bench for the isolated DIO core, host model on the bus.
// Assumes TICK_DIV 1, so code n needs 2**n clocks of steady input.
`timescale 1ns/1ps
module tb;
    import idf_pkg::*;
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, din_i, dout_o;
    int failures, n_checks, n, k;
    logic [31:0] rsp;

    idf_dio_top #(.N_CH(32), .TICK_DIV(1)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .din_i(din_i), .dout_o(dout_o), .irq_o(irq_o));

    idf_host_model u_host (
        .clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
        .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
        .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));

    // 40 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        u_host.xfer(1'b1, a, d, 4'hf, v);
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        u_host.xfer(1'b0, a, 32'h0000_0000, 4'hf, v);
        chk(name, exp, v);
    endtask : rd

    // Pin value as it stood over the last cycle; keeps later stimulus on the edge
    task automatic pin(input string name, input logic [31:0] exp, input logic [31:0] got);
        chk(name, exp, got);
    endtask : pin

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask : wait_cyc

    // Pulse one input for c clocks
    task automatic pulse(input int b, input int c);
        @(posedge clk_i);
        din_i[b] <= 1'b1;
        wait_cyc(c);
        din_i[b] <= 1'b0;
    endtask : pulse

    // Hang guard, far beyond the expected run length
    initial
    begin
        wait_cyc(20000);
        failures++;
        $display("[ERR] watchdog expected done seen hang");
        finish_test();
    end

    initial
    begin
        failures = 0;
        n_checks = 0;
        rst_i = 1'b1;
        ce_i = 1'b1;
        din_i = 32'h0000_0000;
        wait_cyc(4);
        rst_i <= 1'b0;
        // Reset values
        rd("dout reg", OFF_DOUT, 32'h0000_0000);
        pin("dout pins", 32'h0000_0000, dout_o);
        rd("fcode", OFF_FCODE, 32'h0000_0000);
        rd("mask", OFF_MASK, 32'hffff_ffff);
        rd("edge", OFF_EDGE, 32'h0000_0000);
        rd("status", OFF_STAT, 32'h0000_0000);
        pin("irq", 32'h0, {31'h0, irq_o});
        rd("unmapped", 8'h40, 32'h0000_0000);
        // Output latch and read-back
        wr(OFF_DOUT, 32'ha5a5_0f0f);
        pin("dout pins", 32'ha5a5_0f0f, dout_o);
        rd("dout reg", OFF_DOUT, 32'ha5a5_0f0f);
        pin("dout kept", 32'ha5a5_0f0f, dout_o);
        // Unfiltered input, all channels masked
        @(posedge clk_i);
        din_i <= 32'h1234_5678;
        wait_cyc(6);
        rd("din raw", OFF_DIN, 32'h1234_5678);
        din_i <= 32'h0000_0000;
        wait_cyc(6);
        rd("status masked", OFF_STAT, 32'h0000_0000);
        // One code serves every channel; delay grows as 2**n
        for (int i = 0; i < 3; i++)
        begin
            n = 2 * i + 1;
            wr(OFF_FCODE, n);
            wr(OFF_MASK, ~(32'h1 << n));
            @(posedge clk_i);
            din_i[n] <= 1'b1;
            k = 0;
            do
            begin
                @(posedge clk_i);
                #1;
                k++;
            end while (irq_o !== 1'b1 && k < 200);
            n_checks++;
            if (k != (1 << n) + 3)
            begin
                failures++;
                $display("[ERR] irq delay expected %0d seen %0d", (1 << n) + 3, k);
            end
            rd("status src", OFF_STAT, 32'h1 << n);
            pin("irq cleared", 32'h0, {31'h0, irq_o});
            din_i[n] <= 1'b0;
            wait_cyc((1 << n) + 10);
            rd("status fall", OFF_STAT, 32'h0000_0000);
        end
        // Short pulse dropped when filtered, kept when bypassed
        wr(OFF_FCODE, 3);
        wr(OFF_MASK, 32'hffff_fffe);
        pulse(0, 4);
        wait_cyc(20);
        pin("irq glitch", 32'h0, {31'h0, irq_o});
        rd("din glitch", OFF_DIN, 32'h0000_0000);
        wr(OFF_FCODE, 0);
        pulse(0, 4);
        wait_cyc(8);
        pin("irq bypass", 32'h1, {31'h0, irq_o});
        rd("status bypass", OFF_STAT, 32'h0000_0001);
        // Falling edge select
        wr(OFF_MASK, 32'hffff_ff7f);
        wr(OFF_EDGE, 32'h0000_0080);
        rd("edge", OFF_EDGE, 32'h0000_0080);
        @(posedge clk_i);
        din_i[7] <= 1'b1;
        wait_cyc(8);
        pin("irq on rise", 32'h0, {31'h0, irq_o});
        din_i[7] <= 1'b0;
        wait_cyc(30);
        pin("irq held", 32'h1, {31'h0, irq_o});
        rd("status fall", OFF_STAT, 32'h0000_0080);
        // Masked edge is neither flagged nor recalled
        wr(OFF_MASK, 32'hffff_ffff);
        pulse(8, 6);
        wait_cyc(8);
        pin("irq masked", 32'h0, {31'h0, irq_o});
        wr(OFF_MASK, 32'hffff_feff);
        rd("status masked", OFF_STAT, 32'h0000_0000);
        // Byte lanes honoured; the filter code needs lane 0
        u_host.xfer(1'b1, OFF_DOUT, 32'h1234_5678, 4'h2, rsp);
        rd("dout lane", OFF_DOUT, 32'ha5a5_560f);
        u_host.xfer(1'b1, OFF_FCODE, 32'h0000_0005, 4'he, rsp);
        rd("fcode lane", OFF_FCODE, 32'h0000_0000);
        // Every channel requests; an edge in the clearing read survives it
        wr(OFF_MASK, 32'h0000_0000);
        wr(OFF_EDGE, 32'h0000_0000);
        @(posedge clk_i);
        din_i <= 32'hffff_fffe;
        wait_cyc(8);
        rd("status all", OFF_STAT, 32'hffff_fffe);
        @(posedge clk_i);
        din_i[0] <= 1'b1;
        wait_cyc(2);
        rd("status old", OFF_STAT, 32'h0000_0000);
        rd("status kept", OFF_STAT, 32'h0000_0001);
        // Clock enable low freezes the input path, status and request
        wr(OFF_EDGE, 32'hffff_ffff);
        @(posedge clk_i);
        ce_i <= 1'b0;
        din_i <= 32'h0000_0000;
        wait_cyc(10);
        pin("irq frozen", 32'h0, {31'h0, irq_o});
        ce_i <= 1'b1;
        wait_cyc(8);
        pin("irq thawed", 32'h1, {31'h0, irq_o});
        // Reset in mid-run, with a request pending
        wr(OFF_FCODE, 4);
        @(posedge clk_i);
        rst_i <= 1'b1;
        wait_cyc(4);
        rst_i <= 1'b0;
        pin("dout rst", 32'h0000_0000, dout_o);
        pin("irq rst", 32'h0, {31'h0, irq_o});
        rd("fcode rst", OFF_FCODE, 32'h0000_0000);
        rd("mask rst", OFF_MASK, 32'hffff_ffff);
        rd("edge rst", OFF_EDGE, 32'h0000_0000);
        rd("status rst", OFF_STAT, 32'h0000_0000);
        rd("dout reg rst", OFF_DOUT, 32'h0000_0000);
        finish_test();
    end
endmodule : tb
